/* File: logic/fidl_regs.sv */
`timescale 1ns/1ps
`default_nettype none
module fidl_regs
(
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        prot_sel,
  input  wire logic [64:0] fan_speed_count,
  input  wire logic [2:0]  addr_strap,
  input  wire logic [2:0]  drive_strap,
  output logic      [7:0]  reg_rdata_ff,
  output logic             rd_valid_ff,
  output logic             prot_wr_ff,
  output logic             locked_ff
);

  ////////////////////////////////////////////////////////////////////////////
  // Decode

  function automatic logic [3:0] hi_nib(input logic [7:0] a);
    hi_nib = a[7:4];
  endfunction

  logic [7:0] speed_low [fidl_pkg::NUM_FANS];
  logic       lock_wr;
  logic       lock_set;
  logic       nxt_locked;
  logic       nxt_prot_wr;
  logic [7:0] feat_val;
  logic [7:0] part_val;
  logic [7:0] nxt_rdata;
  logic [3:0] fan_idx;
  logic       fan_hit;

  assign fan_idx = hi_nib(reg_addr) - fidl_pkg::FAN_FIRST_HIGH_NIBBLE;
  assign fan_hit = (reg_addr[3:0] == fidl_pkg::SPEED_COUNT_LOW_NIBBLE)
                && (hi_nib(reg_addr) >= fidl_pkg::FAN_FIRST_HIGH_NIBBLE)
                && (fan_idx < 4'(fidl_pkg::NUM_FANS));

  ////////////////////////////////////////////////////////////////////////////
  // Per-fan speed count low bytes

  genvar g;
  generate
    for (g = 0; g < fidl_pkg::NUM_FANS; g++)
    begin : g_fan
      fidl_speed_low u_low
      (
        .core_clk        (core_clk),
        .rst_n           (rst_n),
        .fan_speed_count (fan_speed_count[13*g +: 13]),
        .speed_low_ff    (speed_low[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Write protect

  assign lock_wr    = reg_wr && (reg_addr == fidl_pkg::WRITE_PROTECT_CONTROL_ADDR);
  assign lock_set   = lock_wr && reg_wdata[fidl_pkg::LOCK_BIT];
  // Sticky: only reset clears
  assign nxt_locked = locked_ff | lock_set;
  // Protected write strobe gated by lock
  assign nxt_prot_wr = reg_wr && prot_sel && !locked_ff;

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      locked_ff  <= fidl_pkg::LOCK_RESET;
      prot_wr_ff <= 1'h0;
    end
    else
    begin
      locked_ff  <= nxt_locked;
      prot_wr_ff <= nxt_prot_wr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read-only values; writes to them have no decode path

  assign feat_val = {2'h0, addr_strap, drive_strap};
  assign part_val = {fidl_pkg::PART_FAMILY_CODE, fidl_pkg::PART_VARIANT_CODE};

  always_comb
  begin
    nxt_rdata = 8'h00;
    if (fan_hit)
      nxt_rdata = speed_low[fan_idx[2:0]];
    else
      unique case (reg_addr)
        fidl_pkg::WRITE_PROTECT_CONTROL_ADDR: nxt_rdata = {7'h00, locked_ff};
        fidl_pkg::STRAP_FEATURES_ADDR:        nxt_rdata = feat_val;
        fidl_pkg::PART_IDENTIFICATION_ADDR:   nxt_rdata = part_val;
        fidl_pkg::MAKER_IDENTIFICATION_ADDR:  nxt_rdata = fidl_pkg::MAKER_CODE;
        fidl_pkg::SILICON_VERSION_ADDR:       nxt_rdata = fidl_pkg::SILICON_VERSION_CODE;
        default:                              nxt_rdata = 8'h00;
      endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      reg_rdata_ff <= fidl_pkg::READ_DATA_RESET;
      rd_valid_ff  <= 1'h0;
    end
    else
    begin
      reg_rdata_ff <= reg_rd ? nxt_rdata : reg_rdata_ff;
      rd_valid_ff  <= reg_rd;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  property p_lock_sticky;
    @(posedge core_clk) disable iff (!rst_n)
    locked_ff |=> locked_ff;
  endproperty
  a_lock_sticky: assert property (p_lock_sticky) else $error("lock cleared without reset");

  property p_lock_sets;
    @(posedge core_clk) disable iff (!rst_n)
    lock_set |=> locked_ff;
  endproperty
  a_lock_sets: assert property (p_lock_sets) else $error("lock not set by write");

  property p_prot_blocked;
    @(posedge core_clk) disable iff (!rst_n)
    (reg_wr && prot_sel && locked_ff) |=> !prot_wr_ff;
  endproperty
  a_prot_blocked: assert property (p_prot_blocked) else $error("protected write while locked");

  property p_prot_pass;
    @(posedge core_clk) disable iff (!rst_n)
    (reg_wr && prot_sel && !locked_ff) |=> prot_wr_ff;
  endproperty
  a_prot_pass: assert property (p_prot_pass) else $error("protected write dropped");

  sequence s_read_of(logic [7:0] a);
    reg_rd && reg_addr == a;
  endsequence

  property p_lock_read;
    @(posedge core_clk) disable iff (!rst_n)
    s_read_of(fidl_pkg::WRITE_PROTECT_CONTROL_ADDR) |=> reg_rdata_ff == {7'h00, $past(locked_ff)};
  endproperty
  a_lock_read: assert property (p_lock_read) else $error("lock read wrong");

  property p_feat_read;
    @(posedge core_clk) disable iff (!rst_n)
    s_read_of(fidl_pkg::STRAP_FEATURES_ADDR) |=>
      reg_rdata_ff == {2'h0, $past(addr_strap), $past(drive_strap)};
  endproperty
  a_feat_read: assert property (p_feat_read) else $error("features read wrong");

  property p_maker_read;
    @(posedge core_clk) disable iff (!rst_n)
    s_read_of(fidl_pkg::MAKER_IDENTIFICATION_ADDR) |=> reg_rdata_ff == fidl_pkg::MAKER_CODE;
  endproperty
  a_maker_read: assert property (p_maker_read) else $error("maker read wrong");

  property p_part_read;
    @(posedge core_clk) disable iff (!rst_n)
    s_read_of(fidl_pkg::PART_IDENTIFICATION_ADDR) |=>
      reg_rdata_ff == {fidl_pkg::PART_FAMILY_CODE, fidl_pkg::PART_VARIANT_CODE};
  endproperty
  a_part_read: assert property (p_part_read) else $error("part read wrong");

  property p_rev_read;
    @(posedge core_clk) disable iff (!rst_n)
    s_read_of(fidl_pkg::SILICON_VERSION_ADDR) |=> reg_rdata_ff == fidl_pkg::SILICON_VERSION_CODE;
  endproperty
  a_rev_read: assert property (p_rev_read) else $error("revision read wrong");

  property p_fan1_read;
    @(posedge core_clk) disable iff (!rst_n)
    s_read_of(fidl_pkg::FAN1_SPEED_COUNT_LOW_ADDR) ##1 1'h1 |->
      reg_rdata_ff == {$past(fan_speed_count[4:0], 2), 3'h0};
  endproperty
  a_fan1_read: assert property (p_fan1_read) else $error("fan1 low byte wrong");

  property p_ro_write;
    @(posedge core_clk) disable iff (!rst_n)
    (reg_wr && reg_addr == fidl_pkg::MAKER_IDENTIFICATION_ADDR) ##2 s_read_of(fidl_pkg::MAKER_IDENTIFICATION_ADDR)
      |=> reg_rdata_ff == fidl_pkg::MAKER_CODE;
  endproperty
  a_ro_write: assert property (p_ro_write) else $error("read-only changed by write");

endmodule
`default_nettype wire

/* File: pkg/fidl_pkg.sv */
package fidl_pkg;

  localparam int unsigned NUM_FANS = 5;

  // Register offsets
  localparam logic [7:0] FAN1_SPEED_COUNT_LOW_ADDR  = 8'h3F;
  localparam logic [7:0] FAN2_SPEED_COUNT_LOW_ADDR  = 8'h4F;
  localparam logic [7:0] FAN3_SPEED_COUNT_LOW_ADDR  = 8'h5F;
  localparam logic [7:0] FAN4_SPEED_COUNT_LOW_ADDR  = 8'h6F;
  localparam logic [7:0] FAN5_SPEED_COUNT_LOW_ADDR  = 8'h7F;
  localparam logic [3:0] SPEED_COUNT_LOW_NIBBLE     = 4'hF;
  localparam logic [3:0] FAN_FIRST_HIGH_NIBBLE      = 4'h3;
  localparam logic [7:0] WRITE_PROTECT_CONTROL_ADDR = 8'hEF;
  localparam logic [7:0] STRAP_FEATURES_ADDR        = 8'hFC;
  localparam logic [7:0] PART_IDENTIFICATION_ADDR   = 8'hFD;
  localparam logic [7:0] MAKER_IDENTIFICATION_ADDR  = 8'hFE;
  localparam logic [7:0] SILICON_VERSION_ADDR       = 8'hFF;

  // Field positions
  localparam int unsigned SPEED_LOW_LSB     = 3;
  localparam int unsigned LOCK_BIT          = 0;
  localparam int unsigned FEAT_ADDR_LSB     = 3;
  localparam int unsigned FEAT_DRIVE_LSB    = 0;
  localparam int unsigned PART_FAMILY_LSB   = 2;

  // Reset values
  localparam logic [7:0] SPEED_COUNT_LOW_RESET = 8'h00;
  localparam logic       LOCK_RESET            = 1'h0;
  localparam logic [7:0] READ_DATA_RESET       = 8'h00;

  // Identity codes, values arbitrary
  localparam logic [5:0] PART_FAMILY_CODE  = 6'h2A;
  localparam logic [1:0] PART_VARIANT_CODE = 2'h2;
  localparam logic [7:0] MAKER_CODE        = 8'hA5;
  localparam logic [7:0] SILICON_VERSION_CODE = 8'h01;

  // Default drive level encodings
  localparam logic [2:0] DRIVE_100 = 3'h4;
  localparam logic [2:0] DRIVE_75  = 3'h3;
  localparam logic [2:0] DRIVE_50  = 3'h2;
  localparam logic [2:0] DRIVE_30  = 3'h1;
  localparam logic [2:0] DRIVE_0   = 3'h0;

endpackage

/* File: logic/fidl_speed_low.sv */
`timescale 1ns/1ps
`default_nettype none
module fidl_speed_low
(
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic [12:0] fan_speed_count,
  output var  logic [7:0]  speed_low_ff
);

  logic [7:0] nxt_speed_low;

  // Low five count bits, weights 16..1, low bits zero
  assign nxt_speed_low = {fan_speed_count[4:0], 3'h0};

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      speed_low_ff <= fidl_pkg::SPEED_COUNT_LOW_RESET;
    else
      speed_low_ff <= nxt_speed_low;
  end

endmodule
`default_nettype wire

/* File: tb/fidl_regs_test.sv */
`timescale 1ns/1ps
`default_nettype none
module fidl_regs_test;
  logic        core_clk;
  logic        rst_n;
  logic [7:0]  reg_addr;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_wdata;
  logic        prot_sel;
  logic [64:0] fan_speed_count;
  logic [2:0]  addr_strap;
  logic [2:0]  drive_strap;
  logic [7:0]  reg_rdata_ff;
  logic        rd_valid_ff;
  logic        prot_wr_ff;
  logic        locked_ff;
  logic [12:0] cnt [5];
  int          miscompares;
  int          total_checks;
  int          i;
  fidl_regs u_fidl_regs
  (
    .core_clk        (core_clk),
    .rst_n           (rst_n),
    .reg_addr        (reg_addr),
    .reg_wr          (reg_wr),
    .reg_rd          (reg_rd),
    .reg_wdata       (reg_wdata),
    .prot_sel        (prot_sel),
    .fan_speed_count (fan_speed_count),
    .addr_strap      (addr_strap),
    .drive_strap     (drive_strap),
    .reg_rdata_ff    (reg_rdata_ff),
    .rd_valid_ff     (rd_valid_ff),
    .prot_wr_ff      (prot_wr_ff),
    .locked_ff       (locked_ff)
  );
  always #25 core_clk = ~core_clk;
  assign fan_speed_count = {cnt[4], cnt[3], cnt[2], cnt[1], cnt[0]};
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(posedge core_clk);
    #1;
    reg_rd = 1'b0;
    check("rd_valid", {7'h00, rd_valid_ff}, 8'h01);
    check("rdata", reg_rdata_ff, exp);
    // Idle edge so a following strobe is a fresh pulse
    @(posedge core_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic s, input logic exp_pw);
    reg_addr  = a;
    reg_wdata = d;
    prot_sel  = s;
    reg_wr    = 1'b1;
    @(posedge core_clk);
    #1;
    reg_wr   = 1'b0;
    prot_sel = 1'b0;
    check("prot_wr", {7'h00, prot_wr_ff}, {7'h00, exp_pw});
    // Idle edge so a following strobe is a fresh pulse
    @(posedge core_clk);
    #1;
  endtask
  task automatic do_reset;
    rst_n = 1'b0;
    repeat (5) @(posedge core_clk);
    #1;
    rst_n = 1'b1;
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    core_clk    = 1'h0;
    rst_n       = 1'h0;
    reg_addr    = 8'h00;
    reg_wr      = 1'h0;
    reg_rd      = 1'h0;
    reg_wdata   = 8'h00;
    prot_sel    = 1'h0;
    addr_strap  = 3'h0;
    drive_strap = 3'h0;
    for (i = 0; i < 5; i++)
      cnt[i] = 13'h1FF8 | 13'(i);
    do_reset;
    // Speed count low bytes, two count patterns
    for (int p = 0; p < 2; p++)
    begin
      if (p == 1)
        for (i = 0; i < 5; i++)
          cnt[i] = 13'h0007 + 13'(4 * i);
      repeat (3) @(posedge core_clk);
      #1;
      for (i = 0; i < 5; i++)
        rd({4'(3 + i), 4'hF}, {cnt[i][4:0], 3'h0});
    end
    $display("test speed_low done");
    // Strap features, address codes 5..0 and drive codes 0..4
    for (i = 0; i < 6; i++)
    begin
      addr_strap  = 3'(5 - i);
      drive_strap = 3'(i % 5);
      rd(fidl_pkg::STRAP_FEATURES_ADDR, {2'h0, 3'(5 - i), 3'(i % 5)});
    end
    wr(fidl_pkg::STRAP_FEATURES_ADDR, 8'hFF, 1'b0, 1'b0);
    rd(fidl_pkg::STRAP_FEATURES_ADDR, {2'h0, 3'h0, 3'h0});
    $display("test strap done");
    // Identification registers, write attempts ignored
    for (int k = 0; k < 2; k++)
    begin
      wr(fidl_pkg::PART_IDENTIFICATION_ADDR, 8'h00, 1'b0, 1'b0);
      rd(fidl_pkg::PART_IDENTIFICATION_ADDR, {fidl_pkg::PART_FAMILY_CODE, fidl_pkg::PART_VARIANT_CODE});
      wr(fidl_pkg::MAKER_IDENTIFICATION_ADDR, 8'h00, 1'b0, 1'b0);
      rd(fidl_pkg::MAKER_IDENTIFICATION_ADDR, fidl_pkg::MAKER_CODE);
      wr(fidl_pkg::SILICON_VERSION_ADDR, 8'hFE, 1'b0, 1'b0);
      rd(fidl_pkg::SILICON_VERSION_ADDR, fidl_pkg::SILICON_VERSION_CODE);
    end
    rd(8'h10, 8'h00);
    $display("test ident done");
    // Write protect sequence
    rd(fidl_pkg::WRITE_PROTECT_CONTROL_ADDR, 8'h00);
    wr(fidl_pkg::WRITE_PROTECT_CONTROL_ADDR, 8'hFE, 1'b0, 1'b0);
    rd(fidl_pkg::WRITE_PROTECT_CONTROL_ADDR, 8'h00);
    wr(8'h20, 8'h5A, 1'b1, 1'b1);
    wr(fidl_pkg::WRITE_PROTECT_CONTROL_ADDR, 8'hFF, 1'b0, 1'b0);
    check("locked", {7'h00, locked_ff}, 8'h01);
    rd(fidl_pkg::WRITE_PROTECT_CONTROL_ADDR, 8'h01);
    wr(8'h20, 8'h5A, 1'b1, 1'b0);
    wr(fidl_pkg::WRITE_PROTECT_CONTROL_ADDR, 8'h00, 1'b0, 1'b0);
    rd(fidl_pkg::WRITE_PROTECT_CONTROL_ADDR, 8'h01);
    wr(8'h30, 8'hA5, 1'b1, 1'b0);
    do_reset;
    check("locked", {7'h00, locked_ff}, 8'h00);
    rd(fidl_pkg::WRITE_PROTECT_CONTROL_ADDR, 8'h00);
    wr(8'h20, 8'h5A, 1'b1, 1'b1);
    $display("test protect done");
    print_verdict;
  end
  initial
  begin
    repeat (5000) @(posedge core_clk);
    miscompares++;
    print_verdict;
  end
endmodule
`default_nettype wire
